// File: core/amc_map.svh
// amc_map.svh: register offsets, field positions, reset values and timing counts
// assumes: included by the mode-control package users; definitions only
`ifndef AMC_MAP_SVH
`define AMC_MAP_SVH
// -------------------------------------------------
// register offsets (7-bit address field)
// -------------------------------------------------
`define AMC_ADDR_SOFT_RESET 7'h00
`define AMC_ADDR_FMT_PWR 7'h01
// -------------------------------------------------
// field positions
// -------------------------------------------------
`define AMC_RESET_BIT 7
`define AMC_DUTY_OFF_BIT 7
`define AMC_SCRAMBLE_BIT 6
`define AMC_SIGNED_BIT 5
`define AMC_SLEEP_BIT 4
`define AMC_FRAME_BITS 5'h10
`define AMC_FMT_PWR_RESET 8'h00
// -------------------------------------------------
// timing counts
// -------------------------------------------------
`define AMC_NAP_WAKE_CYCLES 8'h64
`define AMC_SOFT_SLEEP_CYCLES 4'h8
`endif

// File: core/amc_pkg.sv
// amc_pkg.sv: types shared by the mode-control port
// assumes: nothing beyond the map header
package amc_pkg;
   // frame state
   typedef enum logic [2:0] {
      FR_IDLE  = 3'b001,
      FR_SHIFT = 3'b010,
      FR_DONE  = 3'b100
   } amc_frame_e;
   // mode settings handed to the converter core
   typedef struct packed {
      logic twoLane16;
      logic lowCurrent;
      logic termEnable;
      logic dutyStabOff;
      logic scrambleEn;
      logic signedFmt;
      logic sleep;
      logic [3:0] nap;
   } amc_mode_s;
endpackage : amc_pkg

// File: core/amc_mode_port.sv
// amc_mode_port.sv: serial/parallel mode-control port of a four-channel converter
// assumes: pins arrive asynchronous to core_clk; sck far slower than core_clk
// Functional notes
// - select low: pins form serial register link
// - one access is one 16-bit frame
// - frame starts at cs fall; sample sdi
// - sck edges past sixteen are ignored
// - cs rising ends the frame
// - order: rw, address msb-first, data msb-first
// - rw zero writes data to addressed register
// - rw one returns register on sdo
// - read frame changes nothing, ignores sdi data
// - sdo only pulls low, open drain
// - parallel cs: low two-lane16, high one-lane14
// - parallel sck: low 3.5mA, high 1.75mA
// - parallel sdi high puts device asleep
// - parallel sdo high enables termination
// - soft reset clears registers, brief sleep
// - soft reset bit self-clears after frame
// - reset register write-only, low bits unused
// - bit 7 disables duty stabilizer
// - bit 6 enables output scrambler
// - bit 5 selects two's complement
// - bit 4 sleeps whole device
// - bits 3..0 nap channels independently
// - scrambler xors lsb into upper bits
// - nap wake takes at least 100 cycles
`timescale 1ns/1ps
`default_nettype none
`include "amc_map.svh"
module amc_mode_port (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // interface pins
   input wire logic interface_select,
   input wire logic csPin_n,
   input wire logic sckPin,
   input wire logic sdiPin,
   input wire logic sdoIn,
   output logic sdoOut,
   output logic sdoOe,
   // sample data path (one channel word, for the scrambler)
   input wire logic [13:0] rawData,
   output logic [13:0] outData,
   // mode settings to the converter core
   output amc_pkg::amc_mode_s mode,
   output logic [3:0] chanValid
);
   // -------------------------------------------------
   // pin synchronisers
   // -------------------------------------------------
   logic [4:0] syncA; // first stage, read only by syncB
   logic [4:0] syncB; // second stage
   logic sckLast; // previous synced sck, for edge find
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         // sck resets to its idle low level so no false edge follows reset
         syncA <= 5'h1b;
         syncB <= 5'h1b;
         sckLast <= 1'b0;
      end else begin
         syncA <= {interface_select, csPin_n, sckPin, sdiPin, sdoIn};
         syncB <= syncA;
         sckLast <= syncB[2];
      end
   end
   logic selPar, csN, sck, sdi, sdoPin, sckRise;
   assign selPar = syncB[4];
   assign csN = syncB[3];
   assign sck = syncB[2];
   assign sdi = syncB[1];
   assign sdoPin = syncB[0];
   assign sckRise = sck & ~sckLast;
   // -------------------------------------------------
   // serial frame engine
   // -------------------------------------------------
   amc_pkg::amc_frame_e state;
   logic [15:0] shiftIn; // received frame bits
   logic [4:0] bitCnt; // sck rising edges taken
   logic [7:0] fmtPwr; // format and power-down register
   logic [7:0] readShift; // read-back bits
   logic frameEnd; // cs rose this cycle with a frame open
   logic fullFrame;
   logic isRead;
   assign frameEnd = (state != amc_pkg::FR_IDLE) && csN;
   assign fullFrame = (bitCnt == `AMC_FRAME_BITS);
   assign isRead = shiftIn[15];
   // frame state and bit counter
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= amc_pkg::FR_IDLE;
         bitCnt <= 5'h00;
         shiftIn <= 16'h0000;
      end else begin
         case (state)
            amc_pkg::FR_IDLE: begin
               bitCnt <= 5'h00;
               if (!selPar && !csN) begin
                  state <= amc_pkg::FR_SHIFT;
               end
            end
            amc_pkg::FR_SHIFT: begin
               if (csN) begin
                  state <= amc_pkg::FR_IDLE;
               end else if (sckRise) begin
                  shiftIn <= {shiftIn[14:0], sdi};
                  bitCnt <= bitCnt + 5'h01;
                  if (bitCnt == `AMC_FRAME_BITS - 5'h01) begin
                     state <= amc_pkg::FR_DONE;
                  end
               end
            end
            amc_pkg::FR_DONE: begin
               if (csN) begin
                  state <= amc_pkg::FR_IDLE;
               end
            end
            default: begin
               state <= amc_pkg::FR_IDLE;
            end
         endcase
      end
   end
   // -------------------------------------------------
   // register writes and software reset
   // -------------------------------------------------
   logic [3:0] softSleepCnt; // brief sleep after soft reset
   logic resetHit;
   // act only on full 16-bit frames
   assign resetHit = frameEnd && fullFrame && !isRead && shiftIn[14:8] == `AMC_ADDR_SOFT_RESET
                     && shiftIn[`AMC_RESET_BIT];
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         fmtPwr <= `AMC_FMT_PWR_RESET;
      // soft reset clears all mode registers
      end else if (resetHit) begin
         fmtPwr <= `AMC_FMT_PWR_RESET;
      end else if (frameEnd && fullFrame && !isRead && shiftIn[14:8] == `AMC_ADDR_FMT_PWR) begin
         fmtPwr <= shiftIn[7:0];
      end
   end
   // reset bit is a pulse, never stored
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         softSleepCnt <= 4'h0;
      end else if (resetHit) begin
         softSleepCnt <= `AMC_SOFT_SLEEP_CYCLES;
      end else if (softSleepCnt != 4'h0) begin
         softSleepCnt <= softSleepCnt - 4'h1;
      end
   end
   // -------------------------------------------------
   // read-back on open-drain sdo
   // -------------------------------------------------
   // the reset register is write-only and reads as zero
   function automatic logic [7:0] readReg(input logic [6:0] addr, input logic [7:0] fp);
      readReg = (addr == `AMC_ADDR_FMT_PWR) ? fp : 8'h00;
   endfunction : readReg
   logic readActive;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         readShift <= 8'h00;
         readActive <= 1'b0;
      end else if (state != amc_pkg::FR_SHIFT || csN) begin
         readActive <= 1'b0;
      // load after eighth edge, shift on later edges
      end else if (sckRise && bitCnt == 5'h07) begin
         readActive <= shiftIn[6];
         readShift <= readReg({shiftIn[5:0], sdi}, fmtPwr);
      end else if (sckRise && readActive) begin
         readShift <= {readShift[6:0], 1'b1};
      end
   end
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sdoOut <= 1'b0;
         sdoOe <= 1'b0;
      end else begin
         sdoOut <= 1'b0;
         sdoOe <= !selPar && readActive && !readShift[7];
      end
   end
   // -------------------------------------------------
   // mode outputs
   // -------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         mode <= '0;
      end else if (selPar) begin
         mode.twoLane16 <= !csN;
         mode.lowCurrent <= sck;
         mode.sleep <= sdi;
         mode.termEnable <= sdoPin;
         mode.dutyStabOff <= 1'b0;
         mode.scrambleEn <= 1'b0;
         mode.signedFmt <= 1'b0;
         mode.nap <= 4'h0;
      end else begin
         mode.twoLane16 <= 1'b1;
         mode.lowCurrent <= 1'b0;
         mode.termEnable <= 1'b0;
         mode.dutyStabOff <= fmtPwr[`AMC_DUTY_OFF_BIT];
         mode.scrambleEn <= fmtPwr[`AMC_SCRAMBLE_BIT];
         mode.signedFmt <= fmtPwr[`AMC_SIGNED_BIT];
         mode.sleep <= fmtPwr[`AMC_SLEEP_BIT] || softSleepCnt != 4'h0;
         mode.nap <= fmtPwr[`AMC_SLEEP_BIT] ? 4'h0 : fmtPwr[3:0];
      end
   end
   // -------------------------------------------------
   // nap wake-up timers and output data
   // -------------------------------------------------
   logic [7:0] wakeCnt [4]; // per-channel recovery count
   genvar ch;
   generate
      for (ch = 0; ch < 4; ch++) begin : g_wake
         // hold invalid for 100 cycles after nap
         always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
               wakeCnt[ch] <= 8'h00;
               chanValid[ch] <= 1'b0;
            end else begin
               if (mode.nap[ch] || mode.sleep) begin
                  wakeCnt[ch] <= 8'h00;
               end else if (wakeCnt[ch] != `AMC_NAP_WAKE_CYCLES) begin
                  wakeCnt[ch] <= wakeCnt[ch] + 8'h01;
               end
               chanValid[ch] <= !mode.nap[ch] && !mode.sleep && wakeCnt[ch] == `AMC_NAP_WAKE_CYCLES;
            end
         end
      end
   endgenerate
   logic [13:0] fmtData; // offset binary or signed word, before scrambling
   assign fmtData = mode.signedFmt ? {~rawData[13], rawData[12:0]} : rawData;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         outData <= 14'h0000;
      end else begin
         outData <= mode.scrambleEn ? {fmtData[13:1] ^ {13{fmtData[0]}}, fmtData[0]} : fmtData;
      end
   end
   // -------------------------------------------------
   // assertions
   // -------------------------------------------------
   property p_sdo_low_only;
      @(posedge core_clk) disable iff (!rst_n) sdoOe |-> !sdoOut && !$past(selPar);
   endproperty
   a_sdo_low_only: assert property (p_sdo_low_only) else $error("sdo driven high or in strap mode");
   property p_short_frame;
      @(posedge core_clk) disable iff (!rst_n) (frameEnd && !fullFrame) |=> $stable(fmtPwr);
   endproperty
   a_short_frame: assert property (p_short_frame) else $error("short frame changed register");
   property p_write;
      @(posedge core_clk) disable iff (!rst_n)
         (frameEnd && fullFrame && !isRead && shiftIn[14:8] == `AMC_ADDR_FMT_PWR)
         |=> fmtPwr == $past(shiftIn[7:0]);
   endproperty
   a_write: assert property (p_write) else $error("write not stored");
   property p_read_keeps;
      @(posedge core_clk) disable iff (!rst_n) (frameEnd && isRead) |=> $stable(fmtPwr);
   endproperty
   a_read_keeps: assert property (p_read_keeps) else $error("read changed register");
   property p_soft_reset;
      @(posedge core_clk) disable iff (!rst_n) resetHit |=> fmtPwr == 8'h00 ##2 mode.sleep;
   endproperty
   a_soft_reset: assert property (p_soft_reset) else $error("soft reset missed");
   property p_sleep_naps;
      @(posedge core_clk) disable iff (!rst_n)
         (!selPar && fmtPwr[`AMC_SLEEP_BIT]) |=> mode.sleep && mode.nap == 4'h0;
   endproperty
   a_sleep_naps: assert property (p_sleep_naps) else $error("sleep not overriding nap");
   property p_no_extra;
      @(posedge core_clk) disable iff (!rst_n) (state == amc_pkg::FR_DONE && !csN) |=> $stable(shiftIn);
   endproperty
   a_no_extra: assert property (p_no_extra) else $error("edge after sixteenth taken");
   property p_par_lane;
      @(posedge core_clk) disable iff (!rst_n) selPar |=> mode.twoLane16 == !$past(csN);
   endproperty
   a_par_lane: assert property (p_par_lane) else $error("strap lane wrong");
endmodule : amc_mode_port
`default_nettype wire

// File: sim/amc_host_model.sv
// amc_host_model.sv: host side of the serial mode link, frames bit-banged at a 125 ns link clock
// assumes: the bench resolves the sdo wire with a pull-up, drives the cs, sck and sdi straps through this model and the sdo strap itself
`timescale 1ns/1ps
`default_nettype none
module amc_host_model (
   // pins driven toward the port
   output logic csPin_n,
   output logic sckPin,
   output logic sdiPin,
   // resolved sdo wire
   input wire logic sdoWire
);
   // idle: cs high, link clock parked low
   initial begin
      csPin_n = 1'b1;
      sckPin = 1'b0;
      sdiPin = 1'b0;
   end
   task automatic straps(input logic [2:0] lv);
      {csPin_n, sckPin, sdiPin} = lv;
   endtask : straps
   // one frame, rw then address then data
   task automatic frame(input logic [15:0] w, input int edges, output logic [7:0] rd);
      rd = 8'h00;
      csPin_n = 1'b0;
      #62.5;
      for (int i = 0; i < edges; i++) begin
         // extra edges carry junk that must be ignored
         sdiPin = (i < 16) ? w[15 - i] : ~sdiPin;
         #62.5 sckPin = 1'b1;
         // read bits arrive msb first after edge 8
         if (i >= 8 && i < 16) rd = {rd[6:0], sdoWire};
         #62.5 sckPin = 1'b0;
      end
      // line released: show the inverse, not the last bit
      sdiPin = ~sdiPin;
      #62.5 csPin_n = 1'b1;
      #100;
   endtask : frame
endmodule : amc_host_model
`default_nettype wire

// File: sim/adc_mode_control_port_test.sv
// adc_mode_control_port_test.sv: self-checking bench for the mode-control port
// assumes: host model in its own file; sdo wire pulled up outside the port
`timescale 1ns/1ps
`default_nettype none
module adc_mode_control_port_test;
   logic core_clk, rst_n, interface_select, strapSdo, seen;
   logic csPin_n, sckPin, sdiPin, sdoOut, sdoOe, sdoWire;
   logic [13:0] rawData, outData;
   logic [3:0] chanValid;
   logic [7:0] rd, v;
   amc_pkg::amc_mode_s mode;
   int failures, num_checks;
   logic [7:0] vals [6] = '{8'h00, 8'h20, 8'h40, 8'h8f, 8'h1f, 8'h6a};
   assign sdoWire = interface_select ? strapSdo : (sdoOe ? sdoOut : 1'b1);
   // port under test
   amc_mode_port u_dut (.core_clk(core_clk), .rst_n(rst_n), .interface_select(interface_select),
      .csPin_n(csPin_n), .sckPin(sckPin), .sdiPin(sdiPin), .sdoIn(sdoWire), .sdoOut(sdoOut),
      .sdoOe(sdoOe), .rawData(rawData), .outData(outData), .mode(mode), .chanValid(chanValid));
   // far-side host
   amc_host_model u_host (.csPin_n(csPin_n), .sckPin(sckPin), .sdiPin(sdiPin), .sdoWire(sdoWire));
   // 125 MHz clock
   initial core_clk = 1'b0;
   always #4 core_clk = ~core_clk;
   // compare and count
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      num_checks++;
      if (g !== e) begin
         failures++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // step just past a rising edge
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : tick
   task automatic wr(input logic [6:0] a, input logic [7:0] d, input int n);
      u_host.frame({1'b0, a, d}, n, rd);
      // realign to just past a clock edge
      tick(1);
   endtask : wr
   // read frame with junk in the data field
   task automatic rdreg(input logic [6:0] a, input logic [7:0] e);
      u_host.frame({1'b1, a, 8'hff}, 16, rd);
      tick(1);
      chk("read data", {8'h00, e}, {8'h00, rd});
   endtask : rdreg
   // expected word: msb flip for signed, then lsb folded into the rest
   function automatic logic [13:0] fmtWord(logic [13:0] r, logic sg, logic sc);
      logic [13:0] w;
      w = r ^ {sg, 13'h0000};
      if (sc) w[13:1] = w[13:1] ^ {13{w[0]}};
      return w;
   endfunction : fmtWord
   // verdict
   task automatic stop_test;
      $display("checks %0d mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : stop_test
   // watchdog
   initial begin
      #400000;
      failures++;
      stop_test;
   end
   // test sequence
   initial begin
      failures = 0;
      num_checks = 0;
      rst_n = 1'b0;
      interface_select = 1'b0;
      strapSdo = 1'b0;
      rawData = 14'h0000;
      repeat (5) @(posedge core_clk);
      #1 rst_n = 1'b1;
      tick(4);
      chk("mode after reset", 16'h0400, {5'h00, mode});
      // soft reset first, with its brief sleep
      seen = 1'b0;
      fork
         wr(7'h00, 8'h80, 16);
         repeat (400) begin
            tick(1);
            if (mode.sleep === 1'b1) seen = 1'b1;
         end
      join
      chk("reset sleep", 16'h0001, {15'h0000, seen});
      rdreg(7'h00, 8'h00);
      $display("test soft reset done");
      // every field of the format register
      for (int k = 0; k < 6; k++) begin
         v = vals[k];
         wr(7'h01, v, 16);
         chk("mode", {5'h00, 3'h4, v[7:4], v[4] ? 4'h0 : v[3:0]}, {5'h00, mode});
         rdreg(7'h01, v);
         rawData = 14'h1235 ^ {6'h00, v};
         tick(4);
         if (!v[4]) chk("out data", {2'h0, fmtWord(rawData, v[5], v[6])}, {2'h0, outData});
         if (v[4]) chk("valid in sleep", 16'h0000, {12'h000, chanValid});
         else chk("napped valid", 16'h0000, {12'h000, chanValid & v[3:0]});
      end
      rdreg(7'h01, 8'h6a);
      $display("test format register done");
      // refused and overlong frames
      wr(7'h01, 8'h33, 15);
      rdreg(7'h01, 8'h6a);
      wr(7'h02, 8'h33, 16);
      rdreg(7'h01, 8'h6a);
      rdreg(7'h02, 8'h00);
      wr(7'h01, 8'h0c, 20);
      rdreg(7'h01, 8'h0c);
      $display("test frame length done");
      // nap recovery takes at least 100 cycles
      tick(120);
      wr(7'h01, 8'h00, 16);
      tick(60);
      chk("early wake", 16'h0000, {14'h0000, chanValid[3:2]});
      for (int k = 0; k < 100 && chanValid !== 4'hf; k++) tick(1);
      chk("woken", 16'h000f, {12'h000, chanValid});
      $display("test nap wake done");
      // soft reset clears, bit does not stick
      wr(7'h01, 8'h6a, 16);
      wr(7'h00, 8'h80, 16);
      rdreg(7'h01, 8'h00);
      wr(7'h01, 8'h20, 16);
      rdreg(7'h01, 8'h20);
      $display("test reset clear done");
      // parallel straps, all sixteen combinations
      interface_select = 1'b1;
      for (int i = 0; i < 16; i++) begin
         u_host.straps(i[2:0]);
         strapSdo = i[3];
         tick(4);
         chk("straps", {12'h000, ~i[2], i[1], i[3], i[0]},
            {12'h000, mode.twoLane16, mode.lowCurrent, mode.termEnable, mode.sleep});
      end
      interface_select = 1'b0;
      u_host.straps(3'b100);
      tick(6);
      rdreg(7'h01, 8'h20);
      $display("test parallel done");
      stop_test;
   end
endmodule : adc_mode_control_port_test
`default_nettype wire
